// ---- bench/rtc_counter_irq_test.sv ----
// Self-checking bench for the real-time counter register slice, driven over APB.
// Assumes rtc_pkg and a slave that answers at once while clk_en is high.
`timescale 1ns/1ps
module rtc_counter_irq_test
  import rtc_pkg::*;
;
  logic        clock, rst, clk_en, psel, penable, pwrite, pready, pslverr, irq_req, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, d, c0;
  logic [7:0]  en_model;
  int          n_mismatch, n_compared, seed, k;
  logic [31:0] trim_tab [3] = '{32'h0000_007F, 32'h0000_0000, 32'h0000_00FF};
  int          t_tab [3]    = '{20466, 20466, 20486};
  logic [31:0] n_tab [3]    = '{32'h0000_0014, 32'h0000_0013, 32'h0000_0013};

  rtc_counter_irq uut (.clock(clock), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and bus cycles
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high; an idle edge follows so psel never toggles twice
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      complete_run();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Bounded wait for the request line, a tick is 1024 clocks
  task automatic wait_irq();
    k = 0;
    while (irq_req !== 1'b1 && k < 1100) begin
      @(posedge clock);
      k++;
    end
    if (k >= 1100) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // Reads the counter until it moves, so the next window starts just after a tick
  task automatic sync_to_tick();
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    c0 = rd_data;
    k = 0;
    while (rd_data === c0 && k < 600) begin
      apb(1'b0, ADDR_COUNT, 32'h0000_0000);
      k++;
    end
    if (k >= 600) begin
      n_mismatch++;
      complete_run();
    end
    c0 = rd_data;
  endtask

  function automatic logic [7:0] exp_enable(logic [7:0] old, logic [7:0] wd, logic set);
    exp_enable = set ? (old | (wd & IRQ_MASK)) : (old & ~(wd & IRQ_MASK));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 75;
    n_mismatch = 0;
    n_compared = 0;
    en_model = RESET_BYTE;
    {rst, clk_en, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b1, 3'b000, 12'h0_000, 32'h0000_0000};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, ADDR_ENABLE_SET, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    apb(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    check_bit(irq_req, 1'b0);
    $display("test done: reset values");
    // Random set and clear writes; the first is all ones, so every enable bit is hit
    for (int i = 0; i < 16; i++) begin
      d = (i == 0) ? 32'h0000_01FF : $random(seed);
      apb(1'b1, d[8] ? ADDR_ENABLE_SET : ADDR_ENABLE_CLEAR, d);
      en_model = exp_enable(en_model, d[7:0], d[8]);
      apb(1'b0, ADDR_ENABLE_SET, 32'h0000_0000); check_word(rd_data, {24'h00_0000, en_model});
      apb(1'b0, ADDR_ENABLE_CLEAR, 32'h0000_0000); check_word(rd_data, {24'h00_0000, en_model});
    end
    apb(1'b1, ADDR_ENABLE_CLEAR, 32'h0000_00FF);
    $display("test done: enable set and clear");
    // Counter write and read in full-width mode, then the sync-done flag and its request
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(1'b1, ADDR_COUNT, d);
      apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data, d);
    end
    apb(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000); check_word(rd_data, 32'h0000_0040);
    check_bit(irq_req, 1'b0);
    apb(1'b1, ADDR_ENABLE_SET, 32'h0000_0040); check_bit(irq_req, 1'b1);
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h0000_0000);
    apb(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000); check_word(rd_data, 32'h0000_0040);
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h0000_0040); check_bit(irq_req, 1'b0);
    apb(1'b1, ADDR_ENABLE_CLEAR, 32'h0000_0040);
    apb(1'b0, 12'h0_01C, 32'h0000_0000); check_bit(rd_err, 1'b1);
    check_word(rd_data, RESET_WORD);
    $display("test done: sync flag and unmapped read");
    // Wrap from the maximum; compare value still zero, so the alarm flag rises too
    apb(1'b1, ADDR_COUNT, FULL_MAX);
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h0000_00FF);
    apb(1'b1, ADDR_ENABLE_SET, 32'h0000_0080);
    apb(1'b1, ADDR_CONTROL, 32'h0000_0002);
    wait_irq(); check_bit(irq_req, 1'b1);
    apb(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000); check_word(rd_data, 32'h0000_0081);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    apb(1'b1, ADDR_ALARM_ZERO_FLAG, 32'h0000_0001);
    apb(1'b1, ADDR_ENABLE_CLEAR, 32'h0000_0080);
    apb(1'b1, ADDR_ENABLE_SET, 32'h0000_0001);
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h0000_00FF);
    wait_irq(); check_bit(irq_req, 1'b1);
    apb(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000); check_word(rd_data, 32'h0000_0001);
    apb(1'b1, ADDR_ENABLE_CLEAR, 32'h0000_00FF);
    $display("test done: wrap and alarm");
    // Trim: count ticks over a window that separates short, nominal and long periods
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_FREQ_TRIM, trim_tab[i]);
      sync_to_tick();
      repeat (t_tab[i]) @(posedge clock);
      apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data - c0, n_tab[i]);
    end
    apb(1'b0, ADDR_FREQ_TRIM, 32'h0000_0000); check_word(rd_data, 32'h0000_00FF);
    $display("test done: frequency trim");
    // Half-width mode masks the counter to 16 bits; mode only changes while stopped
    apb(1'b1, ADDR_CONTROL, 32'h0000_0000);
    apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    d = $random(seed);
    apb(1'b1, ADDR_COUNT, d);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data, {16'h0000, d[15:0]});
    // Mode bit is locked while running: the second write tries to go back to full width
    apb(1'b1, ADDR_CONTROL, 32'h0000_0003);
    apb(1'b1, ADDR_CONTROL, 32'h0000_0002);
    apb(1'b0, ADDR_CONTROL, 32'h0000_0000); check_word(rd_data, 32'h0000_0003);
    $display("test done: half-width mode");
    // Clock enable low for 2000 clocks: one tick would be due, yet the count must not move
    sync_to_tick();
    clk_en <= 1'b0;
    repeat (2) @(posedge clock);
    check_bit(pready, 1'b0);
    repeat (1998) @(posedge clock);
    clk_en <= 1'b1;
    repeat (500) @(posedge clock);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data, c0);
    $display("test done: clock enable freeze");
    // Reset in mid-run: enables, flags and count return to zero
    apb(1'b1, ADDR_ENABLE_SET, 32'h0000_00FF);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check_bit(irq_req, 1'b0);
    apb(1'b0, ADDR_ENABLE_SET, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    apb(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000); check_word(rd_data, RESET_WORD);
    $display("test done: mid-run reset");
    complete_run();
  end
endmodule

// ---- src/rtc_counter_irq.sv ----
// Real-time counter slice: enables, flags, frequency trim and counter over APB.
// Assumes one clock at 200 MHz and an APB master that holds requests until pready.
//
// Summary of operation
// - Writing one to bit 7 of the enable-set register enables wrap interrupts; zero leaves it.
// - Writing one to bit 6 of the enable-set register enables sync-done interrupts; zero leaves it.
// - Writing one to bit 0 of the enable-set register enables alarm-zero interrupts; zero leaves it.
// - The enable-set register reads back the current enables, all zero after reset.
// - Writing one to a bit of the enable-clear register disables that enable.
// - Each interrupt flag is set by hardware when its condition occurs.
// - The flag register at 0x08 resets to zero and a flag clears only on a written one.
// - All enabled flags are ORed onto one request line, system line number 3.
// - A 7-bit trim magnitude of 1 to 127 adjusts the prescaler; zero disables trim.
// - Trim sign zero speeds the counter up; sign one slows it down.
// - In full-width mode the counter at 0x10 is 32 bits, read/write, reset to zero.
// - In half-width mode the counter at 0x10 is 16 bits, reset to zero, write-protected; here a write still lands, masked to 16 bits.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module rtc_counter_irq
  import rtc_pkg::*;
(
  input  wire logic        clock,     // System clock
  input  wire logic        rst,       // Synchronous reset, active high
  input  wire logic        clk_en,    // Freezes all state while low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB direction
  input  wire logic [11:0] paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error on unmapped address
  output logic             irq_req    // Request to system line 3
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        wr_stb;
  logic        rd_ok;
  logic [7:0]  irq_enable_ff;
  logic [7:0]  irq_flags_ff;
  logic [7:0]  trim_ff;
  logic [1:0]  control_ff;
  logic [31:0] alarm_ff;
  logic [31:0] count_ff;
  logic [15:0] presc_ff;
  logic [7:0]  trim_cnt_ff;
  logic        sync_pend_ff;
  logic        tick;
  logic        wrap_evt;
  logic        alarm_evt;
  logic        sync_evt;
  logic [31:0] cnt_max;
  logic [31:0] nxt_prdata;
  logic        nxt_slverr;
  logic [31:0] cnt_next;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic        mode_wr;
  count_mode_t cur_mode;

  // Checks whether an address is one of ours
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == ADDR_ENABLE_CLEAR) || (a == ADDR_ENABLE_SET) ||
                  (a == ADDR_IRQ_FLAGS) || (a == ADDR_FREQ_TRIM) ||
                  (a == ADDR_COUNT) || (a == ADDR_CONTROL) || (a == ADDR_ALARM_ZERO_FLAG);
  endfunction

  // Next count value: past the mode's maximum the counter wraps to zero
  function automatic logic [31:0] count_after(input logic [31:0] cur, input logic [31:0] top);
    count_after = (cur == top) ? RESET_WORD : cur + 32'h0000_0001;
  endfunction

  // Zero-wait-state slave, but frozen while the clock enable is low
  assign pready = clk_en;
  assign wr_stb = psel && penable && pwrite && clk_en && addr_mapped(paddr);
  assign rd_ok  = addr_mapped(paddr);

  // Read mux and error, registered in the setup cycle so data is a flop output
  always_comb begin
    nxt_prdata = RESET_WORD;
    nxt_slverr = !rd_ok;
    case (paddr)
      ADDR_ENABLE_CLEAR: nxt_prdata = {24'h00_0000, irq_enable_ff};
      ADDR_ENABLE_SET:   nxt_prdata = {24'h00_0000, irq_enable_ff};
      ADDR_IRQ_FLAGS:    nxt_prdata = {24'h00_0000, irq_flags_ff};
      ADDR_FREQ_TRIM:    nxt_prdata = {24'h00_0000, trim_ff};
      ADDR_COUNT:        nxt_prdata = count_ff;
      ADDR_CONTROL:      nxt_prdata = {30'h0000_0000, control_ff};
      ADDR_ALARM_ZERO_FLAG:       nxt_prdata = alarm_ff;
      default:           nxt_prdata = RESET_WORD;
    endcase
  end

  // Read data captured while psel is high and penable low
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= RESET_WORD;
      pslverr <= 1'b0;
    end else if (clk_en && psel && !penable) begin
      prdata  <= nxt_prdata;
      pslverr <= nxt_slverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enables

  // Set and clear registers share one enable vector
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_enable_ff <= RESET_BYTE;
    end else if (clk_en && wr_stb) begin
      if (paddr == ADDR_ENABLE_SET) begin
        irq_enable_ff <= irq_enable_ff | (pwdata[7:0] & IRQ_MASK);
      end else if (paddr == ADDR_ENABLE_CLEAR) begin
        irq_enable_ff <= irq_enable_ff & ~(pwdata[7:0] & IRQ_MASK);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Trim, control and alarm compare; mode may change only while stopped
  always_ff @(posedge clock) begin
    if (rst) begin
      trim_ff    <= RESET_BYTE;
      control_ff <= 2'b00;
      alarm_ff   <= RESET_WORD;
    end else if (clk_en && wr_stb) begin
      if (paddr == ADDR_FREQ_TRIM) begin
        trim_ff <= pwdata[7:0];
      end
      if (paddr == ADDR_CONTROL) begin
        control_ff[BIT_RUN] <= pwdata[BIT_RUN];
        if (!control_ff[BIT_RUN]) begin
          control_ff[BIT_MODE] <= pwdata[BIT_MODE];
        end
      end
      if (paddr == ADDR_ALARM_ZERO_FLAG) begin
        alarm_ff <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler with trim

  // Every TRIM_PERIOD ticks the period is stretched or shrunk by one clock per
  // unit of magnitude, spread as one cycle on the first 'magnitude' ticks.
  logic [15:0] presc_len;
  always_comb begin
    presc_len = PRESCALE_NOM;
    if (trim_ff[6:0] != TRIM_ZERO && trim_cnt_ff < {1'b0, trim_ff[6:0]}) begin
      presc_len = trim_ff[BIT_SIGN] ? PRESCALE_NOM + PRESCALE_ONE
                                    : PRESCALE_NOM - PRESCALE_ONE;
    end
  end

  assign tick = control_ff[BIT_RUN] && (presc_ff + PRESCALE_ONE >= presc_len);

  // Prescaler and trim cadence counters
  always_ff @(posedge clock) begin
    if (rst) begin
      presc_ff    <= 16'h0_000;
      trim_cnt_ff <= RESET_BYTE;
    end else if (clk_en && control_ff[BIT_RUN]) begin
      if (tick) begin
        presc_ff    <= 16'h0_000;
        trim_cnt_ff <= (trim_cnt_ff == TRIM_PERIOD - 8'h01) ? RESET_BYTE : trim_cnt_ff + 8'h01;
      end else begin
        presc_ff <= presc_ff + PRESCALE_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter

  assign cur_mode  = count_mode_t'(control_ff[BIT_MODE]);
  assign cnt_max   = (cur_mode == HALF_WIDTH_COUNT_MODE) ? HALF_MAX : FULL_MAX;
  assign cnt_next  = count_after(count_ff, cnt_max);
  assign wrap_evt  = clk_en && tick && (count_ff == cnt_max);
  // The tick that lands on the compare value raises the alarm, the wrap to zero included
  assign alarm_evt = clk_en && tick && (cnt_next == alarm_ff);
  assign sync_evt  = clk_en && sync_pend_ff;
  // A mode write lands only while stopped; the count is trimmed to the new width then
  assign mode_wr   = wr_stb && (paddr == ADDR_CONTROL) && !control_ff[BIT_RUN];

  // Software write wins over a tick; half mode keeps only 16 bits
  always_ff @(posedge clock) begin
    if (rst) begin
      count_ff <= RESET_WORD;
    end else if (clk_en) begin
      if (wr_stb && paddr == ADDR_COUNT) begin
        count_ff <= pwdata & cnt_max;
      end else if (mode_wr && pwdata[BIT_MODE]) begin
        count_ff <= count_ff & HALF_MAX;
      end else if (tick) begin
        count_ff <= cnt_next;
      end
    end
  end

  // A counter write completes its synchronisation one cycle later
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_pend_ff <= 1'b0;
    end else if (clk_en) begin
      sync_pend_ff <= wr_stb && (paddr == ADDR_COUNT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags and request

  // Clear vector from a write of ones, set vector from the three events
  always_comb begin
    flag_clr = (wr_stb && paddr == ADDR_IRQ_FLAGS) ? (pwdata[7:0] & IRQ_MASK) : RESET_BYTE;
    flag_set = RESET_BYTE;
    flag_set[BIT_WRAP]  = wrap_evt;
    flag_set[BIT_SYNC]  = sync_evt;
    flag_set[BIT_ALARM] = alarm_evt;
  end

  // Set wins over a simultaneous write-one clear so no event is lost
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_flags_ff <= RESET_BYTE;
    end else if (clk_en) begin
      irq_flags_ff <= (irq_flags_ff & ~flag_clr) | flag_set;
    end
  end

  assign irq_req = |(irq_flags_ff & irq_enable_ff);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_enable_set: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_SET && pwdata[BIT_WRAP]) |=> irq_enable_ff[BIT_WRAP])
    else $error("wrap enable not set by write one");

  chk_enable_keep: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_SET && !pwdata[BIT_SYNC]) |=> $stable(irq_enable_ff[BIT_SYNC]))
    else $error("sync enable changed by write zero");

  chk_alarm_en: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_SET && pwdata[BIT_ALARM]) |=> irq_enable_ff[BIT_ALARM])
    else $error("alarm enable not set by write one");

  chk_enable_clear: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_CLEAR && pwdata[BIT_WRAP]) |=> !irq_enable_ff[BIT_WRAP])
    else $error("wrap enable not cleared");

  chk_wrap_flag: assert property (@(posedge clock) disable iff (rst)
    (wrap_evt && !(wr_stb && paddr == ADDR_COUNT))
      |=> irq_flags_ff[BIT_WRAP] && count_ff == RESET_WORD)
    else $error("wrap did not set flag");

  chk_flag_hold: assert property (@(posedge clock) disable iff (rst)
    (irq_flags_ff[BIT_WRAP] && !(wr_stb && paddr == ADDR_IRQ_FLAGS && pwdata[BIT_WRAP]))
      |=> irq_flags_ff[BIT_WRAP])
    else $error("wrap flag cleared without write one");

  chk_irq_line: assert property (@(posedge clock) disable iff (rst)
    (irq_flags_ff[BIT_ALARM] && irq_enable_ff[BIT_ALARM]) |-> irq_req)
    else $error("enabled flag not on request line");

  chk_alarm_flag: assert property (@(posedge clock) disable iff (rst)
    (alarm_evt && !(wr_stb && (paddr == ADDR_COUNT || paddr == ADDR_ALARM_ZERO_FLAG)))
      |=> (irq_flags_ff[BIT_ALARM] && count_ff == alarm_ff))
    else $error("alarm match did not set flag");

  chk_half_range: assert property (@(posedge clock) disable iff (rst)
    control_ff[BIT_MODE] |-> count_ff[31:16] == 16'h0_000)
    else $error("half mode count above 16 bits");

  chk_trim_off: assert property (@(posedge clock) disable iff (rst)
    (trim_ff[6:0] == TRIM_ZERO) |-> presc_len == PRESCALE_NOM)
    else $error("zero trim changed prescaler");

  chk_enable_reset: assert property (@(posedge clock)
    rst |=> (irq_enable_ff == RESET_BYTE))
    else $error("enables not zero after reset");

  chk_flags_reset: assert property (@(posedge clock)
    rst |=> (irq_flags_ff == RESET_BYTE && !irq_req))
    else $error("flags not zero after reset");

  chk_count_reset: assert property (@(posedge clock)
    rst |=> (count_ff == RESET_WORD))
    else $error("count not zero after reset");

  chk_wrap_keep: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_SET && !pwdata[BIT_WRAP]) |=> $stable(irq_enable_ff[BIT_WRAP]))
    else $error("wrap enable changed by write zero");

  chk_sync_set: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_SET && pwdata[BIT_SYNC]) |=> irq_enable_ff[BIT_SYNC])
    else $error("sync enable not set by write one");

  chk_alarm_keep: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_SET && !pwdata[BIT_ALARM]) |=> $stable(irq_enable_ff[BIT_ALARM]))
    else $error("alarm enable changed by write zero");

  chk_alarm_clear: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_ENABLE_CLEAR && pwdata[BIT_ALARM]) |=> !irq_enable_ff[BIT_ALARM])
    else $error("alarm enable not cleared");

  chk_sync_flag: assert property (@(posedge clock) disable iff (rst)
    (clk_en && sync_pend_ff) |=> irq_flags_ff[BIT_SYNC])
    else $error("sync done did not set flag");

  chk_trim_fast: assert property (@(posedge clock) disable iff (rst)
    (trim_ff[6:0] != TRIM_ZERO && !trim_ff[BIT_SIGN] && trim_cnt_ff < {1'b0, trim_ff[6:0]})
      |-> presc_len < PRESCALE_NOM)
    else $error("positive trim did not shorten period");

  chk_trim_slow: assert property (@(posedge clock) disable iff (rst)
    (trim_ff[6:0] != TRIM_ZERO && trim_ff[BIT_SIGN] && trim_cnt_ff < {1'b0, trim_ff[6:0]})
      |-> presc_len > PRESCALE_NOM)
    else $error("negative trim did not stretch period");

  chk_count_write: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && paddr == ADDR_COUNT && !control_ff[BIT_MODE]) |=> count_ff == $past(pwdata))
    else $error("full-width count write lost");

  chk_mode_lock: assert property (@(posedge clock) disable iff (rst)
    control_ff[BIT_RUN] |=> $stable(control_ff[BIT_MODE]))
    else $error("mode changed while running");

  // Clock enable low must hold the count and the flag register
  chk_freeze_count: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(count_ff))
    else $error("count moved while clock enable low");

  chk_freeze_flags: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(irq_flags_ff))
    else $error("flags moved while clock enable low");

  chk_irq_quiet: assert property (@(posedge clock) disable iff (rst)
    (!irq_enable_ff[BIT_WRAP] && !irq_enable_ff[BIT_SYNC] && !irq_enable_ff[BIT_ALARM]) |-> !irq_req)
    else $error("request raised with all enables off");

endmodule

// ---- src/rtc_pkg.sv ----
// Package of constants for the real-time counter register slice.
// Assumes an APB master with 32-bit data and word-aligned byte addresses.
package rtc_pkg;
  localparam logic [11:0] ADDR_ENABLE_CLEAR = 12'h0_000; // Chosen offset
  localparam logic [11:0] ADDR_ENABLE_SET   = 12'h0_004; // Chosen offset
  localparam logic [11:0] ADDR_IRQ_FLAGS    = 12'h0_008;
  localparam logic [11:0] ADDR_FREQ_TRIM    = 12'h0_00C; // Chosen offset
  localparam logic [11:0] ADDR_COUNT        = 12'h0_010;
  localparam logic [11:0] ADDR_CONTROL      = 12'h0_014; // Chosen offset
  localparam logic [11:0] ADDR_ALARM_ZERO_FLAG       = 12'h0_018; // Chosen offset

  localparam int BIT_WRAP  = 7;
  localparam int BIT_SYNC  = 6;
  localparam int BIT_ALARM = 0;
  localparam int BIT_SIGN  = 7;
  localparam int BIT_MODE  = 0;
  localparam int BIT_RUN   = 1;

  localparam logic [7:0]  IRQ_MASK      = 8'hC1;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  localparam logic [31:0] FULL_MAX      = 32'hFFFF_FFFF;
  localparam logic [31:0] HALF_MAX      = 32'h0000_FFFF;
  localparam logic [6:0]  TRIM_ZERO     = 7'h00;
  localparam int          SYSTEM_IRQ_LINE = 3;

  // Prescaler period in clocks and the trim cadence
  localparam logic [15:0] PRESCALE_NOM  = 16'h0_400;
  localparam logic [15:0] PRESCALE_ONE  = 16'h0_001;
  localparam logic [7:0]  TRIM_PERIOD   = 8'h80;

  typedef enum logic [0:0] {
    FULL_WIDTH_COUNT_MODE,
    HALF_WIDTH_COUNT_MODE
  } count_mode_t;
endpackage
